// ---- pkg/scgc_params.svh ----
// Register indices, field positions, reset values and masks of the channel global control bank.
`ifndef SCGC_PARAMS_SVH
`define SCGC_PARAMS_SVH

`define SCGC_IDX_W              18
`define SCGC_IDX_GRP_A_CTRL     18'h3_0005
`define SCGC_IDX_GRP_A_TEST     18'h3_0006
`define SCGC_IDX_CH_AC_COMMON   18'h3_0024
`define SCGC_IDX_CH_AD_COMMON   18'h3_0034
`define SCGC_IDX_GRP_B_CTRL     18'h3_0105
`define SCGC_IDX_GRP_B_TEST     18'h3_0106
`define SCGC_IDX_CH_BC_COMMON   18'h3_0124
`define SCGC_IDX_CH_BD_COMMON   18'h3_0134
`define SCGC_IDX_TX_POWER_DOWN  18'h3_0200
`define SCGC_IDX_STATUS         18'h3_0201

`define SCGC_BIT_SILENCE        1
`define SCGC_BIT_SOFT_RESET     2
`define SCGC_BIT_GRP_TX_PD      3
`define SCGC_BIT_GRP_RX_PD      4
`define SCGC_BIT_TEST_SELECT    7

`define SCGC_CH_COMMON_RESET    8'h02
`define SCGC_CH_COMMON_MASK     8'h86
`define SCGC_GRP_CTRL_RESET     8'h02
`define SCGC_GRP_CTRL_MASK      8'h9e
`define SCGC_TEST_CODE_RESET    5'h00
`define SCGC_TX_PD_RESET        4'h0

`endif

// ---- pkg/scgc_pkg.sv ----
// Types shared by the channel global control bank and its users.
package scgc_pkg;

    typedef enum logic [2:0] {
        BUS_IDLE   = 3'b001,
        BUS_LATCH  = 3'b010,
        BUS_ANSWER = 3'b100
    } scgc_bus_state_e;

    typedef struct packed {
        logic tx_alarm;
        logic rx_alarm;
        logic tx_alarm_mask;
        logic rx_alarm_mask;
    } scgc_alarm_in_s;

    typedef struct packed {
        logic alarm_irq;
        logic tx_power_down;
        logic test_mode;
        logic chan_reset;
    } scgc_chan_ctrl_s;

endpackage

// ---- rtl/scgc_top.sv ----
// Control bank for a two-block, four-channel serial transceiver, reached over APB.
//
// Local design decision: register access over APB.
`include "scgc_params.svh"

module scgc_top (
    // APB clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [19:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Channel alarms, index 0..3 for channels AC, AD, BC, BD
    input  wire scgc_pkg::scgc_alarm_in_s [3:0] chan_alarm,
    // Effective per-channel controls
    output scgc_pkg::scgc_chan_ctrl_s [3:0]    chan_ctrl,
    // Per-block test pattern code and receive power-down, index 0 for block A
    output logic      [1:0][4:0]               test_pattern_code,
    output logic      [1:0]                    group_rx_power_down
);

    localparam int NUM_CH  = 4;
    localparam int NUM_GRP = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.

    scgc_pkg::scgc_bus_state_e     bus_state_reg;
    scgc_pkg::scgc_bus_state_e     bus_state_next;
    logic [31:0]                   prdata_reg;
    logic [31:0]                   prdata_next;
    logic                          pready_reg;
    logic                          pready_next;
    logic                          pslverr_reg;
    logic                          pslverr_next;
    logic [NUM_CH-1:0][7:0]        ch_common_reg;
    logic [NUM_CH-1:0][7:0]        ch_common_next;
    logic [NUM_GRP-1:0][7:0]       grp_ctrl_reg;
    logic [NUM_GRP-1:0][7:0]       grp_ctrl_next;
    logic [NUM_GRP-1:0][4:0]       test_code_reg;
    logic [NUM_GRP-1:0][4:0]       test_code_next;
    logic [NUM_CH-1:0]             tx_pd_reg;
    logic [NUM_CH-1:0]             tx_pd_next;
    scgc_pkg::scgc_chan_ctrl_s [NUM_CH-1:0] chan_ctrl_reg;
    scgc_pkg::scgc_chan_ctrl_s [NUM_CH-1:0] chan_ctrl_next;

    logic [`SCGC_IDX_W-1:0]        reg_index;
    logic                          write_fire;
    logic                          addr_hit;
    logic                          low_lane;
    logic [31:0]                   read_value;
    logic [15:0]                   status_value;

    assign reg_index  = paddr[19:2];
    assign write_fire = psel && penable && pwrite && pready_reg;
    assign low_lane   = pstrb[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode and read data.

    always_comb begin
        status_value = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            status_value[4*c +: 4] = chan_ctrl_reg[c];
        end
        addr_hit   = 1'b1;
        read_value = '0;
        case (reg_index)
            `SCGC_IDX_GRP_A_CTRL: begin
                read_value[7:0] = grp_ctrl_reg[0];
            end
            `SCGC_IDX_GRP_B_CTRL: begin
                read_value[7:0] = grp_ctrl_reg[1];
            end
            `SCGC_IDX_GRP_A_TEST: begin
                read_value[4:0] = test_code_reg[0];
            end
            `SCGC_IDX_GRP_B_TEST: begin
                read_value[4:0] = test_code_reg[1];
            end
            `SCGC_IDX_CH_AC_COMMON: begin
                read_value[7:0] = ch_common_reg[0];
            end
            `SCGC_IDX_CH_AD_COMMON: begin
                read_value[7:0] = ch_common_reg[1];
            end
            `SCGC_IDX_CH_BC_COMMON: begin
                read_value[7:0] = ch_common_reg[2];
            end
            `SCGC_IDX_CH_BD_COMMON: begin
                read_value[7:0] = ch_common_reg[3];
            end
            `SCGC_IDX_TX_POWER_DOWN: begin
                read_value[3:0] = tx_pd_reg;
            end
            `SCGC_IDX_STATUS: begin
                read_value[15:0] = status_value;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB handshake: two wait cycles, so read data and pready come from flip-flops.

    always_comb begin
        bus_state_next = bus_state_reg;
        prdata_next    = prdata_reg;
        pready_next    = 1'b0;
        pslverr_next   = 1'b0;
        case (bus_state_reg)
            scgc_pkg::BUS_IDLE: begin
                if (psel && penable) begin
                    bus_state_next = scgc_pkg::BUS_LATCH;
                end
            end
            scgc_pkg::BUS_LATCH: begin
                prdata_next    = pwrite ? 32'h0000_0000 : read_value;
                pready_next    = 1'b1;
                pslverr_next   = !addr_hit;
                bus_state_next = scgc_pkg::BUS_ANSWER;
            end
            scgc_pkg::BUS_ANSWER: begin
                bus_state_next = scgc_pkg::BUS_IDLE;
            end
            default: begin
                bus_state_next = scgc_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state_reg <= scgc_pkg::BUS_IDLE;
            prdata_reg    <= 32'h0000_0000;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
        end else begin
            bus_state_reg <= bus_state_next;
            prdata_reg    <= prdata_next;
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers; only lane 0 carries the eight-bit fields.

    always_comb begin
        ch_common_next = ch_common_reg;
        grp_ctrl_next  = grp_ctrl_reg;
        test_code_next = test_code_reg;
        tx_pd_next     = tx_pd_reg;
        if (write_fire && low_lane) begin
            case (reg_index)
                `SCGC_IDX_GRP_A_CTRL: begin
                    grp_ctrl_next[0] = pwdata[7:0] & `SCGC_GRP_CTRL_MASK;
                end
                `SCGC_IDX_GRP_B_CTRL: begin
                    grp_ctrl_next[1] = pwdata[7:0] & `SCGC_GRP_CTRL_MASK;
                end
                `SCGC_IDX_GRP_A_TEST: begin
                    test_code_next[0] = pwdata[4:0];
                end
                `SCGC_IDX_GRP_B_TEST: begin
                    test_code_next[1] = pwdata[4:0];
                end
                `SCGC_IDX_CH_AC_COMMON: begin
                    ch_common_next[0] = pwdata[7:0] & `SCGC_CH_COMMON_MASK;
                end
                `SCGC_IDX_CH_AD_COMMON: begin
                    ch_common_next[1] = pwdata[7:0] & `SCGC_CH_COMMON_MASK;
                end
                `SCGC_IDX_CH_BC_COMMON: begin
                    ch_common_next[2] = pwdata[7:0] & `SCGC_CH_COMMON_MASK;
                end
                `SCGC_IDX_CH_BD_COMMON: begin
                    ch_common_next[3] = pwdata[7:0] & `SCGC_CH_COMMON_MASK;
                end
                `SCGC_IDX_TX_POWER_DOWN: begin
                    tx_pd_next = pwdata[3:0];
                end
                default: begin
                    tx_pd_next = tx_pd_reg;
                end
            endcase
        end
    end

    // Soft resets never touch these; only the hardware reset does.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                ch_common_reg[c] <= `SCGC_CH_COMMON_RESET;
            end
            for (int g = 0; g < NUM_GRP; g++) begin
                grp_ctrl_reg[g]  <= `SCGC_GRP_CTRL_RESET;
                test_code_reg[g] <= `SCGC_TEST_CODE_RESET;
            end
            tx_pd_reg <= `SCGC_TX_PD_RESET;
        end else begin
            ch_common_reg <= ch_common_next;
            grp_ctrl_reg  <= grp_ctrl_next;
            test_code_reg <= test_code_next;
            tx_pd_reg     <= tx_pd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Effective per-channel controls; channels 0 and 1 belong to block A.

    always_comb begin
        logic [7:0] cc;
        logic [7:0] gc;
        logic       silenced;
        logic       tx_hit;
        logic       rx_hit;
        cc       = '0;
        gc       = '0;
        silenced = 1'b0;
        tx_hit   = 1'b0;
        rx_hit   = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            cc       = ch_common_reg[c];
            gc       = grp_ctrl_reg[c/2];
            silenced = gc[`SCGC_BIT_SILENCE] | cc[`SCGC_BIT_SILENCE];
            tx_hit   = chan_alarm[c].tx_alarm & ~chan_alarm[c].tx_alarm_mask;
            rx_hit   = chan_alarm[c].rx_alarm & ~chan_alarm[c].rx_alarm_mask;
            chan_ctrl_next[c].alarm_irq     = (tx_hit | rx_hit) & ~silenced;
            chan_ctrl_next[c].chan_reset    = gc[`SCGC_BIT_SOFT_RESET]
                                            | cc[`SCGC_BIT_SOFT_RESET];
            chan_ctrl_next[c].tx_power_down = gc[`SCGC_BIT_GRP_TX_PD]
                                            | tx_pd_reg[c];
            chan_ctrl_next[c].test_mode     = gc[`SCGC_BIT_TEST_SELECT]
                                            | cc[`SCGC_BIT_TEST_SELECT];
        end
    end

    // The hardware reset holds every channel in reset as well.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                chan_ctrl_reg[c] <= 4'b0001;
            end
        end else begin
            chan_ctrl_reg <= chan_ctrl_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign prdata    = prdata_reg;
    assign pready    = pready_reg;
    assign pslverr   = pslverr_reg;
    assign chan_ctrl = chan_ctrl_reg;

    always_comb begin
        for (int g = 0; g < NUM_GRP; g++) begin
            test_pattern_code[g]   = test_code_reg[g];
            group_rx_power_down[g] = grp_ctrl_reg[g][`SCGC_BIT_GRP_RX_PD];
        end
    end

endmodule

// ---- bench/scgc_checker.sv ----
// Port-level assertions for the channel global control bank.
module scgc_checker (
    // Clock and reset
    input wire logic                            pclk,
    input wire logic                            presetn,
    // APB slave
    input wire logic                            psel,
    input wire logic                            penable,
    input wire logic                            pwrite,
    input wire logic [19:0]                     paddr,
    input wire logic [31:0]                     pwdata,
    input wire logic [3:0]                      pstrb,
    input wire logic [31:0]                     prdata,
    input wire logic                            pready,
    input wire logic                            pslverr,
    // Channel side
    input wire scgc_pkg::scgc_alarm_in_s [3:0]  chan_alarm,
    input wire scgc_pkg::scgc_chan_ctrl_s [3:0] chan_ctrl,
    input wire logic [1:0][4:0]                 test_pattern_code,
    input wire logic [1:0]                      group_rx_power_down
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire logic acc   = psel && penable;
    wire logic wdone = pready && pwrite;

    ////////////////////////////////////////////////////////////////////////////
    property p_ready_wait; $rose(acc) |-> ##2 pready; endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("pready not after two wait cycles");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_err_ready; pslverr |-> pready && acc; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr outside answer cycle");
    property p_wr_rdata; wdone |-> prdata == 32'h0000_0000; endproperty
    a_wr_rdata: assert property (p_wr_rdata) else $error("prdata not zero on write");
    property p_code_hold; $changed({test_pattern_code, group_rx_power_down}) |-> $past(wdone); endproperty
    a_code_hold: assert property (p_code_hold) else $error("test code changed without write");
    property p_rst_cause; $rose(chan_ctrl[0].chan_reset) |-> $past(wdone, 2); endproperty
    a_rst_cause: assert property (p_rst_cause) else $error("channel reset rose without write");
    property p_test_cause; $changed(chan_ctrl[1].test_mode) |-> $past(wdone, 2); endproperty
    a_test_cause: assert property (p_test_cause) else $error("test mode moved without write");
    property p_txpd_cause; $changed(chan_ctrl[2].tx_power_down) |-> $past(wdone, 2); endproperty
    a_txpd_cause: assert property (p_txpd_cause) else $error("tx power-down moved without write");
    property p_irq_cause;
        chan_ctrl[0].alarm_irq |-> $past((chan_alarm[0].tx_alarm && !chan_alarm[0].tx_alarm_mask)
            || (chan_alarm[0].rx_alarm && !chan_alarm[0].rx_alarm_mask));
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without unmasked alarm");

    c_err: cover property (pslverr);
    c_irq: cover property (chan_ctrl[0].alarm_irq);
    c_grp_rst: cover property ($rose(chan_ctrl[2].chan_reset));
endmodule

bind scgc_top scgc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_alarm(chan_alarm), .chan_ctrl(chan_ctrl),
    .test_pattern_code(test_pattern_code), .group_rx_power_down(group_rx_power_down));

// ---- bench/scgc_tb_top.sv ----
// Self-checking bench for the channel global control bank.
`include "scgc_params.svh"
module scgc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [17:0] idx; logic [31:0] rst, wd, rb; logic err;} scgc_row_s;
    logic                            pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [19:0]                     paddr;
    logic [31:0]                     pwdata, prdata, rd;
    logic [3:0]                      pstrb;
    scgc_pkg::scgc_alarm_in_s [3:0]  chan_alarm;
    scgc_pkg::scgc_chan_ctrl_s [3:0] chan_ctrl;
    logic [1:0][4:0]                 test_pattern_code;
    logic [1:0]                      group_rx_power_down;
    int                              n_mismatch, tests_run, cycles;
    localparam logic [17:0] ga = `SCGC_IDX_GRP_A_CTRL;
    localparam logic [17:0] gb = `SCGC_IDX_GRP_B_CTRL;
    localparam logic [17:0] cac = `SCGC_IDX_CH_AC_COMMON;
    scgc_row_s rows [6] = '{
        '{`SCGC_IDX_STATUS, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
        '{ga, 32'h0000_0002, 32'h0000_00FF, 32'h0000_009E, 1'b0},
        '{cac, 32'h0000_0002, 32'h0000_00FF, 32'h0000_0086, 1'b0},
        '{`SCGC_IDX_CH_BD_COMMON, 32'h0000_0002, 32'h0000_0079, 32'h0000_0000, 1'b0},
        '{`SCGC_IDX_GRP_B_TEST, 32'h0000_0000, 32'h0000_00FF, 32'h0000_001F, 1'b0},
        '{18'h3_0007, 32'h0000_0000, 32'h0000_00FF, 32'h0000_0000, 1'b1}};

    scgc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_alarm(chan_alarm), .chan_ctrl(chan_ctrl),
        .test_pattern_code(test_pattern_code), .group_rx_power_down(group_rx_power_down));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic summarize();
        $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Full APB transfer; read data and error are taken at the edge that samples pready.
    task automatic apb(input logic w, input logic [17:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [17:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
        repeat (2) @(posedge pclk);
    endtask

    task automatic ctl(input logic [15:0] exp);
        check("chan_ctrl", {16'h0000, chan_ctrl}, {16'h0000, exp});
    endtask

    task automatic alarm(input logic [15:0] v);
        @(posedge pclk);
        chan_alarm <= v;
        repeat (3) @(posedge pclk);
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        ctl(16'h1111);
        presetn <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        chan_alarm = '0;
        do_reset();
        foreach (rows[i]) begin
            apb(1'b0, rows[i].idx, 32'h0000_0000);
            check("reset_value", rd, rows[i].rst);
            check("pslverr", {31'h0, err}, {31'h0, rows[i].err});
            apb(1'b1, rows[i].idx, rows[i].wd);
            apb(1'b0, rows[i].idx, 32'h0000_0000);
            check("readback", rd, rows[i].rb);
        end
        do_reset();
        alarm(16'h8888);
        ctl(16'h0000);
        wr(cac, 32'h0000_0000);
        ctl(16'h0000);
        wr(ga, 32'h0000_0000);
        ctl(16'h0008);
        alarm(16'hAAAA);
        ctl(16'h0000);
        alarm(16'h4444);
        ctl(16'h0008);
        wr(cac, 32'h0000_0002);
        ctl(16'h0000);
        wr(cac, 32'h0000_0006);
        repeat (20) @(posedge pclk);
        ctl(16'h0001);
        apb(1'b0, cac, 32'h0000_0000);
        check("soft_reset_kept", rd, 32'h0000_0006);
        wr(gb, 32'h0000_0006);
        ctl(16'h1101);
        wr(cac, 32'h0000_0002);
        wr(gb, 32'h0000_0002);
        ctl(16'h0000);
        wr(`SCGC_IDX_CH_AD_COMMON, 32'h0000_0082);
        ctl(16'h0020);
        wr(gb, 32'h0000_0082);
        ctl(16'h2220);
        wr(`SCGC_IDX_GRP_A_TEST, 32'h0000_0015);
        check("test_code", {22'h0, test_pattern_code}, 32'h0000_0015);
        wr(`SCGC_IDX_TX_POWER_DOWN, 32'h0000_0001);
        ctl(16'h2224);
        wr(gb, 32'h0000_000A);
        ctl(16'h4424);
        pstrb <= 4'h0;
        wr(gb, 32'h0000_0000);
        pstrb <= 4'hF;
        ctl(16'h4424);
        wr(ga, 32'h0000_0012);
        check("rx_pd", {30'h0, group_rx_power_down}, 32'h0000_0001);
        apb(1'b0, `SCGC_IDX_STATUS, 32'h0000_0000);
        check("status", rd, 32'h0000_4424);
        summarize();
    end
endmodule
